//--- pkg/ext_irq_defines.svh
// Purpose: Register indices, field positions and reset values of the
//          external interrupt edge and priority slice.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// ==========================================================
// Register indices (byte address = index * 4)
`define IDX_TIMER_CTL     8'h88
`define IDX_PRIO_SECOND   8'hb9
`define IDX_G0_FALL       8'hba
`define IDX_G0_RISE       8'hbb
`define IDX_G1_FALL       8'hbc
`define IDX_G1_RISE       8'hbd
`define IDX_G2_FALL       8'hc6
`define IDX_G2_RISE       8'hc7
`define IDX_ENABLE_CTL    8'hf0
`define IDX_PRIO_EXT      8'hf1
`define IDX_SERVICE_STAT  8'hf2

// ==========================================================
// Field positions
`define BIT_G1_FLAG       3
`define BIT_G0_FLAG       1
`define BIT_TOUCH_PRIO    4
`define BIT_G2_PRIO       3
`define BIT_BTM_PRIO      2
`define BIT_PWM_PRIO      1
`define BIT_SERIAL_PRIO   0
`define BIT_GLOBAL_EN     7
`define BIT_TOUCH_EN      6
`define BIT_G2_EN         5
`define BIT_BTM_EN        4
`define BIT_PWM_EN        3
`define BIT_SERIAL_EN     2
`define BIT_G1_EN         1
`define BIT_G0_EN         0
`define BIT_G1_PRIO       1
`define BIT_G0_PRIO       0
`define BIT_G2_FLAG       0
`define BIT_LOW_BUSY      1
`define BIT_HIGH_BUSY     2
`define G0_FIRST_LINE     1
`define G0_LINES          3

// ==========================================================
// Source slots in query order, smallest serves first within a priority level
`define SLOT_G0           3'h0
`define SLOT_G1           3'h1
`define SLOT_SERIAL       3'h2
`define SLOT_PWM          3'h3
`define SLOT_BTM          3'h4
`define SLOT_G2           3'h5
`define SLOT_TOUCH        3'h6
`define NUM_SLOTS         7

// ==========================================================
// Reset values and bus constants
`define RST_BYTE          8'h00
`define RST_WORD          32'h0000_0000
`define APB_AW            12
`endif

//--- pkg/ext_irq_pkg.sv
// Purpose: Types shared by the external interrupt slice.
// Assumes: Constants live in ext_irq_defines.svh.
// Notes:   One-hot service state.
package ext_irq_pkg;

  // ==========================================================
  // In-service nesting state
  typedef enum logic [3:0] {
    SVC_IDLE     = 4'b0001,
    SVC_LOW      = 4'b0010,
    SVC_HIGH     = 4'b0100,
    SVC_LOW_HIGH = 4'b1000
  } svc_state_t;

  typedef logic [7:0] sfr_byte_t;

endpackage

//--- hw/ext_irq_edge_priority.sv
// Purpose: Edge-triggered external interrupt groups, request flags and
//          two-level priority arbitration toward the CPU, on an APB slave.
// Assumes: CPU pulses irq_ack when it vectors to the presented request
//          and irq_return on return_from_interrupt; peripheral requests
//          are levels on pclk.
// Notes:   Zero-wait APB; unmapped or unaligned addresses give pslverr.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "ext_irq_defines.svh"

module ext_irq_edge_priority
  import ext_irq_pkg::*;
#(
  parameter int G1_LINES = 4,
  parameter int G2_LINES = 6
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [`APB_AW-1:0]   paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // External interrupt pins
  input  wire logic [`G0_LINES:1]   group0_pin,
  input  wire logic [G1_LINES-1:0]  group1_pin,
  input  wire logic [G2_LINES-1:0]  group2_pin,
  // Peripheral request levels
  input  wire logic                 touch_req,
  input  wire logic                 base_timer_req,
  input  wire logic                 pwm_req,
  input  wire logic                 serial_req,
  // CPU side
  input  wire logic                 irq_ack,
  input  wire logic                 irq_return,
  output logic                      irq_req,
  output logic      [2:0]           irq_slot,
  output logic                      irq_high
);

  localparam int NLINES = `G0_LINES + G1_LINES + G2_LINES;
  localparam int G1_LO  = `G0_LINES;
  localparam int G2_LO  = `G0_LINES + G1_LINES;

  // ==========================================================
  // Elaboration checks: register fields hold at most 4 and 6 lines
  if (G1_LINES < 1 || G1_LINES > 4) begin : g_bad_g1
    $error("G1_LINES must be 1 to 4");
  end
  if (G2_LINES < 1 || G2_LINES > 6) begin : g_bad_g2
    $error("G2_LINES must be 1 to 6");
  end

  // ==========================================================
  // Registers
  sfr_byte_t  prio_second;
  sfr_byte_t  g0_fall, g0_rise, g1_fall, g1_rise, g2_fall, g2_rise;
  sfr_byte_t  enable_ctl;
  sfr_byte_t  prio_ext;
  logic       group0_request_flag;
  logic       group1_request_flag;
  logic       group2_flag;
  svc_state_t svc;

  // ==========================================================
  // Address decode, used by read mux and write strobes
  function automatic logic hit(input logic [`APB_AW-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  function automatic logic mapped(input logic [`APB_AW-1:0] a);
    mapped = hit(a, `IDX_TIMER_CTL)   || hit(a, `IDX_PRIO_SECOND) ||
             hit(a, `IDX_G0_FALL)     || hit(a, `IDX_G0_RISE)     ||
             hit(a, `IDX_G1_FALL)     || hit(a, `IDX_G1_RISE)     ||
             hit(a, `IDX_G2_FALL)     || hit(a, `IDX_G2_RISE)     ||
             hit(a, `IDX_ENABLE_CTL)  || hit(a, `IDX_PRIO_EXT)    ||
             hit(a, `IDX_SERVICE_STAT);
  endfunction

  logic setup_ph;
  logic wr_go;
  assign setup_ph = psel & ~penable;
  assign wr_go    = psel & penable & pready & pwrite & ~pslverr;

  function automatic logic wr_to(input logic go,
                                 input logic [`APB_AW-1:0] a,
                                 input logic [7:0] idx);
    wr_to = go & hit(a, idx);
  endfunction

  // ==========================================================
  // Edge detection: three-stage sync, change counts when 2 and 3 agree
  logic [NLINES-1:0] pin_all, sync1, sync2, sync3, level;
  logic [NLINES-1:0] fall_en, rise_en, edge_hit;

  assign pin_all = {group2_pin, group1_pin, group0_pin};
  // Reserved enable bits never reach the lines
  assign fall_en = {g2_fall[G2_LINES-1:0], g1_fall[G1_LINES-1:0],
                    g0_fall[`G0_LINES:`G0_FIRST_LINE]};
  assign rise_en = {g2_rise[G2_LINES-1:0], g1_rise[G1_LINES-1:0],
                    g0_rise[`G0_LINES:`G0_FIRST_LINE]};

  // Synchroniser chain; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pin_all;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NLINES; gi++) begin : g_line
      logic settled;
      assign settled = (sync2[gi] == sync3[gi]);
      // One event per settled transition, either edge if both enabled
      assign edge_hit[gi] = settled && (sync3[gi] != level[gi]) &&
        ((sync3[gi] && rise_en[gi]) ||
         (!sync3[gi] && fall_en[gi]));

      // Previous settled value of the line
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level[gi] <= 1'b0;
        end else if (settled) begin
          level[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  logic g0_evt, g1_evt, g2_evt;
  assign g0_evt = |edge_hit[G1_LO-1:0];
  assign g1_evt = |edge_hit[G2_LO-1:G1_LO];
  assign g2_evt = |edge_hit[NLINES-1:G2_LO];

  // ==========================================================
  // Arbitration: request and level vectors in query order
  logic [`NUM_SLOTS-1:0] pend, prio, hi_cand, lo_cand;
  logic                  hi_busy, any_busy;

  assign pend = {touch_req & enable_ctl[`BIT_TOUCH_EN],
                 group2_flag & enable_ctl[`BIT_G2_EN],
                 base_timer_req & enable_ctl[`BIT_BTM_EN],
                 pwm_req & enable_ctl[`BIT_PWM_EN],
                 serial_req & enable_ctl[`BIT_SERIAL_EN],
                 group1_request_flag & enable_ctl[`BIT_G1_EN],
                 group0_request_flag & enable_ctl[`BIT_G0_EN]};
  assign prio = {prio_second[`BIT_TOUCH_PRIO],
                 prio_second[`BIT_G2_PRIO],
                 prio_second[`BIT_BTM_PRIO],
                 prio_second[`BIT_PWM_PRIO],
                 prio_second[`BIT_SERIAL_PRIO],
                 prio_ext[`BIT_G1_PRIO],
                 prio_ext[`BIT_G0_PRIO]};

  assign hi_busy  = (svc == SVC_HIGH) || (svc == SVC_LOW_HIGH);
  assign any_busy = (svc != SVC_IDLE);
  // High may cut into low service; same level waits for return
  assign hi_cand = pend & prio & {`NUM_SLOTS{~hi_busy}};
  assign lo_cand = pend & ~prio & {`NUM_SLOTS{~any_busy}};

  // Lowest set bit is the smallest query number
  function automatic logic [2:0] first_slot(input logic [6:0] v);
    first_slot = 3'h0;
    for (int i = `NUM_SLOTS - 1; i >= 0; i--) begin
      if (v[i]) first_slot = 3'(i);
    end
  endfunction

  logic       pick_any, pick_high;
  logic [2:0] pick_slot;
  assign pick_any  = enable_ctl[`BIT_GLOBAL_EN] &&
                     ((|hi_cand) || (|lo_cand));
  assign pick_high = |hi_cand;
  assign pick_slot = pick_high ? first_slot(hi_cand)
                               : first_slot(lo_cand);

  // Request to CPU; dropped for a cycle after ack so the same slot is
  // not offered twice while flags and service state settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req  <= 1'b0;
      irq_slot <= `SLOT_G0;
      irq_high <= 1'b0;
    end else begin
      irq_req  <= pick_any & ~(irq_ack & irq_req);
      irq_slot <= pick_slot;
      irq_high <= pick_high;
    end
  end

  logic taken;
  assign taken = irq_ack & irq_req;

  // ==========================================================
  // Service nesting: push on ack, pop innermost on return
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc <= SVC_IDLE;
    end else if (taken) begin
      case (svc)
        SVC_IDLE: svc <= irq_high ? SVC_HIGH : SVC_LOW;
        SVC_LOW:  svc <= SVC_LOW_HIGH;
        default:  svc <= svc;
      endcase
    end else if (irq_return) begin
      case (svc)
        SVC_LOW_HIGH: svc <= SVC_LOW;
        SVC_LOW:      svc <= SVC_IDLE;
        SVC_HIGH:     svc <= SVC_IDLE;
        default:      svc <= SVC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Request flags: an event in the clearing cycle wins
  logic clr_g0, clr_g1, clr_g2;
  logic wr_timer_ctl_irq_flags;
  assign clr_g0  = taken && (irq_slot == `SLOT_G0);
  assign clr_g1  = taken && (irq_slot == `SLOT_G1);
  assign clr_g2  = taken && (irq_slot == `SLOT_G2);
  assign wr_timer_ctl_irq_flags = wr_to(wr_go, paddr, `IDX_TIMER_CTL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group0_request_flag <= 1'b0;
    end else if (wr_timer_ctl_irq_flags) begin
      group0_request_flag <= pwdata[`BIT_G0_FLAG] | g0_evt;
    end else begin
      group0_request_flag <= (group0_request_flag & ~clr_g0)
                             | g0_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group1_request_flag <= 1'b0;
    end else if (wr_timer_ctl_irq_flags) begin
      group1_request_flag <= pwdata[`BIT_G1_FLAG] | g1_evt;
    end else begin
      group1_request_flag <= (group1_request_flag & ~clr_g1)
                             | g1_evt;
    end
  end

  // Group 2 flag is not writable; it reads at service status bit 0 and is held here until served
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group2_flag <= 1'b0;
    end else begin
      group2_flag <= (group2_flag & ~clr_g2) | g2_evt;
    end
  end

  // ==========================================================
  // Software registers; reserved bits are never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_second <= `RST_BYTE;
      g0_fall     <= `RST_BYTE;
      g0_rise     <= `RST_BYTE;
      g1_fall     <= `RST_BYTE;
      g1_rise     <= `RST_BYTE;
      g2_fall     <= `RST_BYTE;
      g2_rise     <= `RST_BYTE;
      enable_ctl  <= `RST_BYTE;
      prio_ext    <= `RST_BYTE;
    end else begin
      if (wr_to(wr_go, paddr, `IDX_PRIO_SECOND))
        prio_second <= {3'b000, pwdata[4:0]};
      if (wr_to(wr_go, paddr, `IDX_G0_FALL))
        g0_fall <= {4'h0, pwdata[3:1], 1'b0};
      if (wr_to(wr_go, paddr, `IDX_G0_RISE))
        g0_rise <= {4'h0, pwdata[3:1], 1'b0};
      if (wr_to(wr_go, paddr, `IDX_G1_FALL))
        g1_fall <= {4'h0, pwdata[3:0]};
      if (wr_to(wr_go, paddr, `IDX_G1_RISE))
        g1_rise <= {4'h0, pwdata[3:0]};
      if (wr_to(wr_go, paddr, `IDX_G2_FALL))
        g2_fall <= {2'b00, pwdata[5:0]};
      if (wr_to(wr_go, paddr, `IDX_G2_RISE))
        g2_rise <= {2'b00, pwdata[5:0]};
      if (wr_to(wr_go, paddr, `IDX_ENABLE_CTL))
        enable_ctl <= pwdata[7:0];
      if (wr_to(wr_go, paddr, `IDX_PRIO_EXT))
        prio_ext <= {6'h00, pwdata[1:0]};
    end
  end

  // ==========================================================
  // Read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = `RST_BYTE;
    if (hit(paddr, `IDX_TIMER_CTL)) begin
      rd_byte[`BIT_G1_FLAG] = group1_request_flag;
      rd_byte[`BIT_G0_FLAG] = group0_request_flag;
    end
    if (hit(paddr, `IDX_PRIO_SECOND))  rd_byte = prio_second;
    if (hit(paddr, `IDX_G0_FALL))      rd_byte = g0_fall;
    if (hit(paddr, `IDX_G0_RISE))      rd_byte = g0_rise;
    if (hit(paddr, `IDX_G1_FALL))      rd_byte = g1_fall;
    if (hit(paddr, `IDX_G1_RISE))      rd_byte = g1_rise;
    if (hit(paddr, `IDX_G2_FALL))      rd_byte = g2_fall;
    if (hit(paddr, `IDX_G2_RISE))      rd_byte = g2_rise;
    if (hit(paddr, `IDX_ENABLE_CTL))   rd_byte = enable_ctl;
    if (hit(paddr, `IDX_PRIO_EXT))     rd_byte = prio_ext;
    if (hit(paddr, `IDX_SERVICE_STAT)) begin
      rd_byte[`BIT_G2_FLAG]   = group2_flag;
      rd_byte[`BIT_LOW_BUSY]  = (svc == SVC_LOW) ||
                                (svc == SVC_LOW_HIGH);
      rd_byte[`BIT_HIGH_BUSY] = hi_busy;
    end
  end

  // ==========================================================
  // APB answer: captured in setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `RST_WORD;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= {24'h000000, rd_byte};
      pready  <= 1'b1;
      pslverr <= ~mapped(paddr);
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // ext_irq_edge_priority

//--- tb/ext_irq_edge_priority_chk.sv
// Purpose: Port-level checker for the external interrupt slice.
// Assumes: Zero-wait APB; CPU acks and returns by one-cycle pulses.
// Notes:   Service nesting is tracked from irq_ack and irq_return.
`timescale 1ns/10ps
`include "ext_irq_defines.svh"

module ext_irq_edge_priority_chk #(
  parameter int G1_LINES = 4,
  parameter int G2_LINES = 6
) (
  // Clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [`APB_AW-1:0]  paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // CPU side
  input wire logic                irq_ack,
  input wire logic                irq_return,
  input wire logic                irq_req,
  input wire logic [2:0]          irq_slot,
  input wire logic                irq_high
);
  logic gen;
  logic low_busy;
  logic high_busy;
  logic rd_setup;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Helper state: global enable copy and service nesting
  assign rd_setup = psel && !penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gen <= 1'b0;
    else if (psel && penable && pready && pwrite && !pslverr &&
             paddr == {2'b00, `IDX_ENABLE_CTL, 2'b00})
      gen <= pwdata[`BIT_GLOBAL_EN];
  end
  // Ack wins over return, as the core does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_busy  <= 1'b0;
      high_busy <= 1'b0;
    end else if (irq_ack && irq_req) begin
      if (irq_high) high_busy <= 1'b1;
      else low_busy <= 1'b1;
    end else if (irq_return) begin
      if (high_busy) high_busy <= 1'b0;
      else low_busy <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  a_pready_follows: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_ack_drops_req: assert property (irq_ack && irq_req |=> !irq_req)
    else $error("request still up after ack");
  a_global_gates_req: assert property (!gen |=> !irq_req)
    else $error("request with global enable off");
  a_high_no_preempt: assert property (high_busy |-> !irq_req)
    else $error("request during high level service");
  a_low_same_level: assert property (low_busy |-> !irq_req || irq_high)
    else $error("low request during low level service");
  a_prio_reserved: assert property (rd_setup &&
    paddr == {2'b00, `IDX_PRIO_SECOND, 2'b00} |=> prdata[31:5] == 27'h0)
    else $error("reserved priority bits read nonzero");
  a_g0_reserved: assert property (rd_setup && paddr[11:3] ==
    9'h05d |=> prdata[31:4] == 28'h0 && !prdata[0])
    else $error("reserved group 0 bits read nonzero");
  a_g1_reserved: assert property (rd_setup && paddr[11:3] ==
    9'h05e |=> prdata[31:4] == 28'h0)
    else $error("reserved group 1 bits read nonzero");
  a_g2_reserved: assert property (rd_setup && paddr[11:3] ==
    9'h063 |=> prdata[31:6] == 26'h0)
    else $error("reserved group 2 bits read nonzero");
  a_slot_in_range: assert property (
    irq_req |-> irq_slot < 3'(`NUM_SLOTS))
    else $error("request names no source");

  // Scenario coverage
  c_high_take: cover property (irq_ack && irq_req && irq_high);
  c_nested:    cover property (low_busy && high_busy);
  c_refused:   cover property (pready && pslverr);
endmodule // ext_irq_edge_priority_chk

bind ext_irq_edge_priority ext_irq_edge_priority_chk #(
  .G1_LINES(G1_LINES), .G2_LINES(G2_LINES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq_ack(irq_ack),
  .irq_return(irq_return), .irq_req(irq_req), .irq_slot(irq_slot),
  .irq_high(irq_high));

//--- tb/cpu_core_model.sv
// Purpose: CPU core model that takes requests and returns from service.
// Assumes: Ack only while irq_req is high; return asked by the bench.
// Notes:   ack_wait sets how slowly the core responds.
`timescale 1ns/10ps

module cpu_core_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Request from the block
  input  wire logic       irq_req,
  input  wire logic [2:0] irq_slot,
  input  wire logic       irq_high,
  // Bench control
  input  wire logic [3:0] ack_wait,
  input  wire logic       ret_ask,
  // Answers
  output logic            irq_ack,
  output logic            irq_return,
  output logic [7:0]      n_taken,
  output logic [2:0]      last_slot,
  output logic            last_high
);
  logic [3:0] seen;

  // ==========================================================
  // Ack after the request stood ack_wait cycles; one pulse per take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen <= 4'h0;
      irq_ack <= 1'b0;
      n_taken <= 8'h00;
      last_slot <= 3'h0;
      last_high <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      seen <= (irq_req && !irq_ack) ? seen + 4'h1 : 4'h0;
      if (irq_req && !irq_ack && seen >= ack_wait) begin
        irq_ack <= 1'b1;
        n_taken <= n_taken + 8'h01;
        last_slot <= irq_slot;
        last_high <= irq_high;
      end
    end
  end
  // Return pulse mirrors the bench's one-cycle ask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_return <= 1'b0;
    else irq_return <= ret_ask;
  end
endmodule // cpu_core_model

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the external interrupt slice.
// Assumes: Zero-wait APB slave; byte address is four times the index.
// Notes:   Peripheral requests are dropped by the bench once taken.
`timescale 1ns/10ps
`include "ext_irq_defines.svh"

module tb_top;
  import ext_irq_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ret_ask;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, irq_ack, irq_return, irq_req, irq_high;
  logic [3:1]  g0_pin;
  logic [3:0]  g1_pin, preq, ack_wait;
  logic [5:0]  g2_pin;
  logic [2:0]  irq_slot, last_slot;
  logic [7:0]  n_taken, prev;
  logic        last_high;
  int          n_errors, total_checks, cycles;

  // ==========================================================
  // Clock, design and core model
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  ext_irq_edge_priority u_ext_irq_edge_priority (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .group0_pin(g0_pin), .group1_pin(g1_pin),
    .group2_pin(g2_pin), .touch_req(preq[3]), .base_timer_req(preq[2]),
    .pwm_req(preq[1]), .serial_req(preq[0]), .irq_ack(irq_ack),
    .irq_return(irq_return), .irq_req(irq_req), .irq_slot(irq_slot),
    .irq_high(irq_high));
  cpu_core_model u_cpu_core_model (.pclk(pclk), .presetn(presetn),
    .irq_req(irq_req), .irq_slot(irq_slot), .irq_high(irq_high),
    .ack_wait(ack_wait), .ret_ask(ret_ask), .irq_ack(irq_ack),
    .irq_return(irq_return), .n_taken(n_taken), .last_slot(last_slot),
    .last_high(last_high));

  // ==========================================================
  // Shared tasks
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until pready is sampled high; answer taken there
  // No wait limit here: only the bench timeout ends a hung transfer
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d, output logic [32:0] r);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ba(idx);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, idx, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, idx, 32'h0, r);
    check(r[31:0], exp[31:0]);
    check({31'h0, r[32]}, {31'h0, exp[32]});
  endtask
  // Wait, with no limit of its own, for the core model to take one request
  task automatic take(input logic [2:0] slot, input logic hi);
    while (n_taken === prev) @(posedge pclk);
    prev = n_taken;
    check({28'h0, hi, last_slot}, {28'h0, hi, slot});
    check({31'h0, last_high}, {31'h0, hi});
  endtask
  task automatic ret();
    @(posedge pclk); ret_ask <= 1'b1;
    @(posedge pclk); ret_ask <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic idle_chk(input int n);
    repeat (n) @(posedge pclk);
    check({24'h0, n_taken}, {24'h0, prev});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0]  idx [8] = '{`IDX_TIMER_CTL, `IDX_PRIO_SECOND, `IDX_G0_FALL,
      `IDX_G0_RISE, `IDX_G1_FALL, `IDX_G1_RISE, `IDX_G2_FALL, `IDX_G2_RISE};
    logic [31:0] msk [8] = '{32'h0a, 32'h1f, 32'h0e, 32'h0e, 32'h0f,
      32'h0f, 32'h3f, 32'h3f};
    for (int i = 0; i < 8; i++) rd_chk(idx[i], 33'h0);
    for (int i = 1; i < 8; i++) begin
      wr(idx[i], 32'hff);
      rd_chk(idx[i], {1'b0, msk[i]});
      wr(idx[i], 32'h0);
    end
    rd_chk(8'h01, 33'h1_0000_0000);
  endtask
  task automatic t_edges();
    wr(`IDX_G0_RISE, 32'h02); wr(`IDX_G0_FALL, 32'h08);
    g0_pin[1] <= 1'b1; repeat (5) @(posedge pclk);
    rd_chk(`IDX_TIMER_CTL, 33'h02); wr(`IDX_TIMER_CTL, 32'h0);
    g0_pin[1] <= 1'b0; g0_pin[3] <= 1'b1; repeat (6) @(posedge pclk);
    rd_chk(`IDX_TIMER_CTL, 33'h00);
    g0_pin[3] <= 1'b0; repeat (5) @(posedge pclk);
    rd_chk(`IDX_TIMER_CTL, 33'h02); wr(`IDX_TIMER_CTL, 32'h0);
    wr(`IDX_G1_RISE, 32'h01); wr(`IDX_G1_FALL, 32'h01);
    g1_pin[0] <= 1'b0; repeat (5) @(posedge pclk);
    rd_chk(`IDX_TIMER_CTL, 33'h08); wr(`IDX_TIMER_CTL, 32'h0);
    g1_pin[0] <= 1'b1; repeat (5) @(posedge pclk);
    rd_chk(`IDX_TIMER_CTL, 33'h08); wr(`IDX_TIMER_CTL, 32'h0);
    wr(`IDX_G2_RISE, 32'h20); wr(`IDX_G2_FALL, 32'h01);
    g2_pin[5] <= 1'b1; repeat (5) @(posedge pclk);
    rd_chk(`IDX_SERVICE_STAT, 33'h01);
  endtask
  task automatic t_deliver();
    wr(`IDX_ENABLE_CTL, 32'h01); g0_pin[1] <= 1'b1;
    idle_chk(12);
    ack_wait <= 4'h5; wr(`IDX_ENABLE_CTL, 32'h81);
    take(`SLOT_G0, 1'b0); rd_chk(`IDX_TIMER_CTL, 33'h0); ret();
    wr(`IDX_ENABLE_CTL, 32'h82); wr(`IDX_G1_FALL, 32'h08);
    g1_pin[3] <= 1'b0; ack_wait <= 4'h0;
    take(`SLOT_G1, 1'b0); rd_chk(`IDX_TIMER_CTL, 33'h0); ret();
  endtask
  task automatic t_order();
    wr(`IDX_PRIO_SECOND, 32'h04); wr(`IDX_ENABLE_CTL, 32'h9c);
    preq <= 4'b0011; take(`SLOT_SERIAL, 1'b0); preq[0] <= 1'b0;
    idle_chk(10);
    preq[2] <= 1'b1; take(`SLOT_BTM, 1'b1); preq[2] <= 1'b0;
    ret(); idle_chk(10);
    ret(); take(`SLOT_PWM, 1'b0); preq <= 4'h0; ret();
  endtask
  task automatic t_prio();
    int pb [4] = '{0, 1, 2, 4};
    int eb [4] = '{2, 3, 4, 6};
    logic [2:0] sl [4] = '{`SLOT_SERIAL, `SLOT_PWM, `SLOT_BTM, `SLOT_TOUCH};
    for (int i = 0; i < 4; i++) begin
      ack_wait <= 4'(i * 3);
      wr(`IDX_PRIO_SECOND, 32'h1 << pb[i]);
      wr(`IDX_ENABLE_CTL, 32'h80 | (32'h1 << eb[i]));
      preq[i] <= 1'b1; take(sl[i], 1'b1); preq[i] <= 1'b0;
      ret();
    end
    // Group 2 flag still pending from the edge scenario
    wr(`IDX_PRIO_SECOND, 32'h08); wr(`IDX_ENABLE_CTL, 32'ha0);
    take(`SLOT_G2, 1'b1);
    rd_chk(`IDX_SERVICE_STAT, 33'h04); ret();
  endtask

  // ==========================================================
  // Main sequence, timeout and verdict
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    n_errors = 0; total_checks = 0; cycles = 0; prev = 8'h00;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; g0_pin = 3'h0; g1_pin = 4'hf;
    g2_pin = 6'h00; preq = 4'h0; ack_wait = 4'h0; ret_ask = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_edges();
    t_deliver();
    t_order();
    t_prio();
    test_done();
  end
endmodule // tb_top
